// ### rtl/kwdt_counter.sv
// binary up-counter with selectable terminal count for the watchdog
`default_nettype none
module kwdt_counter (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // control
  input wire logic i_clear,
  input wire logic i_tick,
  input wire logic [4:0] i_width,
  // status
  output logic o_wrap,
  output logic [kwdt_pkg::COUNT_W-1:0] o_count
);
  logic [kwdt_pkg::COUNT_W-1:0] count_reg;
  logic [kwdt_pkg::COUNT_W-1:0] count_next;
  logic [kwdt_pkg::COUNT_W-1:0] term_mask;
  logic [4:0] shift_amt;

  // terminal count is 2^width - 1, width from 11 to 20
  assign shift_amt = kwdt_pkg::COUNT_W5 - i_width;
  assign term_mask = {kwdt_pkg::COUNT_W{1'b1}} >> shift_amt;
  assign o_wrap = i_tick && (count_reg == term_mask);
  assign o_count = count_reg;

  // clear wins over counting; wrap returns to zero
  assign count_next = (i_clear || o_wrap) ? '0 :
                      i_tick ? count_reg + 1'b1 : count_reg;

  // counter storage
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) count_reg <= '0;
    else count_reg <= count_next;
  end
endmodule // kwdt_counter
`default_nettype wire

// ### rtl/kwdt_pkg.sv
// package of constants for the keyed watchdog timer
`default_nettype none
package kwdt_pkg;
  // register addresses
  localparam logic [15:0] MODE_ADDR = 16'hFF48;
  localparam logic [15:0] KEY_ADDR = 16'hFF49;
  // reset and fixed values
  localparam logic [7:0] MODE_RESET = 8'h67;
  localparam logic [7:0] KEY_READ_VALUE = 8'h9A;
  localparam logic [7:0] RESTART_KEY = 8'hAC;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  // mode register field positions
  localparam int CLK_SEL_STOP_POS = 4;
  localparam int CLK_SEL_SOURCE_POS = 3;
  localparam int INTERVAL_MSB = 2;
  localparam int INTERVAL_LSB = 0;
  // interval exponent bases for each counting source
  localparam logic [4:0] LOW_SPEED_BASE = 5'h0B;
  localparam logic [4:0] SYSTEM_BASE = 5'h0D;
  // counter geometry
  localparam int COUNT_W = 20;
  localparam logic [4:0] COUNT_W5 = 5'h14;
endpackage : kwdt_pkg
`default_nettype wire

// ### rtl/kwdt_top.sv
// keyed watchdog timer: mode and key registers, clock gating, overflow reset
// Behaviour
// - system-clock source gated when stopped, halted, stabilizing
// - low-speed source gated in halt/stop or oscillator off
// - non-stoppable low-speed oscillator runs except in reset
// - mode register resets to 67H, counting starts
// - select bits: 00 low, 01 system, 1x stop
// - non-stoppable option forces low-speed source
// - interval 2^(11+n) low or 2^(13+n) system
// - after reset interval field is all ones
// - mode writable once; later writes force reset
// - first write stopping watchdog suppresses those resets
// - key ACH clears counter and resumes counting
// - non-key write to key register forces reset
// - bit operation on key register forces reset
// - key register always reads back 9AH
// - overflow issues reset and sets cause flag
// - first write of mode register clears the counter
// - paused counter keeps value and resumes later
// - non-stoppable option means watchdog never stops
`default_nettype none
module kwdt_top (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst_b,
  // register access port
  input wire logic [15:0] i_addr,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic i_bit_op,
  input wire logic [7:0] i_wr_data,
  output logic [7:0] o_rd_data,
  // power and clock status
  input wire logic i_option_nonstop,
  input wire logic i_low_speed_osc_clk,
  input wire logic i_halt,
  input wire logic i_stop,
  input wire logic i_system_clk_stopped,
  input wire logic i_osc_stabilizing,
  input wire logic i_cpu_on_system_clk,
  input wire logic i_low_speed_sw_stop,
  // outputs
  output logic o_internal_reset,
  output logic o_watchdog_reset_cause_flag,
  output logic o_low_speed_osc_en
);
  logic [7:0] watchdog_mode_reg;
  logic [7:0] watchdog_mode_next;
  logic mode_written_reg;
  logic first_stopped_reg;
  logic strap_taken_reg;
  logic nonstop_reg;
  logic [2:0] low_sync_reg;
  logic int_reset_next;
  logic [7:0] rd_data_next;
  logic [kwdt_pkg::COUNT_W-1:0] count_val;
  logic wrap;

  // address decode and access classification
  wire sel_mode = (i_addr == kwdt_pkg::MODE_ADDR);
  wire sel_key = (i_addr == kwdt_pkg::KEY_ADDR);
  wire mode_wr = i_wr && sel_mode;
  wire key_wr = i_wr && sel_key;
  wire key_good = key_wr && !i_bit_op && (i_wr_data == kwdt_pkg::RESTART_KEY);
  wire key_bad = key_wr && !key_good;
  wire mode_first = mode_wr && !mode_written_reg;
  wire mode_again = mode_wr && mode_written_reg;

  // decoded mode fields
  wire clk_sel_stop_bit = watchdog_mode_reg[kwdt_pkg::CLK_SEL_STOP_POS];
  wire clk_sel_source_bit = watchdog_mode_reg[kwdt_pkg::CLK_SEL_SOURCE_POS];
  wire [2:0] interval_sel =
    watchdog_mode_reg[kwdt_pkg::INTERVAL_MSB:kwdt_pkg::INTERVAL_LSB];
  wire wdt_stopped = clk_sel_stop_bit && !nonstop_reg;
  wire src_system = clk_sel_source_bit && !nonstop_reg;
  wire stop_at_first = i_wr_data[kwdt_pkg::CLK_SEL_STOP_POS] && !nonstop_reg;

  // counting enables per source; a gated tick leaves the count alone
  wire low_edge = low_sync_reg[1] && !low_sync_reg[2];
  wire pause_lp = !nonstop_reg && (i_halt || i_stop);
  wire sys_tick = src_system && !i_system_clk_stopped && !i_osc_stabilizing
                  && !i_halt && !i_stop;
  wire low_tick = !src_system && low_edge && !pause_lp
                  && !(i_cpu_on_system_clk && i_low_speed_sw_stop && !nonstop_reg);
  wire tick = !wdt_stopped && (sys_tick || low_tick);

  // interval width: base plus n selects the terminal bit
  wire [4:0] base = src_system ? kwdt_pkg::SYSTEM_BASE : kwdt_pkg::LOW_SPEED_BASE;
  wire [4:0] width = base + {2'b00, interval_sel};
  wire clear = mode_first || key_good;

  // illegal accesses are forgiven only if the first write stopped it
  assign int_reset_next = wrap
    || (!first_stopped_reg && (mode_again || key_bad));

  // first mode write loads; select bits held at low-speed when non-stoppable
  assign watchdog_mode_next = nonstop_reg ?
    {i_wr_data[7:5], 2'b00, i_wr_data[2:0]} : i_wr_data;

  // read data: key register reads fixed value, unmapped reads zero
  assign rd_data_next = sel_mode ? watchdog_mode_reg :
                        sel_key ? kwdt_pkg::KEY_READ_VALUE :
                        kwdt_pkg::UNMAPPED_READ;

  // the counter proper
  kwdt_counter u_counter (
    .i_sys_clk(i_sys_clk),
    .i_rst_b(i_rst_b),
    .i_clear(clear),
    .i_tick(tick),
    .i_width(width),
    .o_wrap(wrap),
    .o_count(count_val)
  );

  // low-speed clock pin synchroniser and edge history
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) low_sync_reg <= 3'h0;
    else low_sync_reg <= {low_sync_reg[1:0], i_low_speed_osc_clk};
  end

  // option strap caught on the first edge after reset release
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      strap_taken_reg <= 1'b0;
      nonstop_reg <= 1'b0;
    end else if (!strap_taken_reg) begin
      strap_taken_reg <= 1'b1;
      nonstop_reg <= i_option_nonstop;
    end
  end

  // mode register and write-once tracking
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      watchdog_mode_reg <= kwdt_pkg::MODE_RESET;
      mode_written_reg <= 1'b0;
      first_stopped_reg <= 1'b0;
    end else if (mode_first) begin
      watchdog_mode_reg <= watchdog_mode_next;
      mode_written_reg <= 1'b1;
      first_stopped_reg <= stop_at_first;
    end
  end

  // reset request, cause flag and read data
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      o_internal_reset <= 1'b0;
      o_watchdog_reset_cause_flag <= 1'b0;
      o_rd_data <= 8'h00;
    end else begin
      o_internal_reset <= int_reset_next;
      if (wrap) o_watchdog_reset_cause_flag <= 1'b1;
      if (i_rd) o_rd_data <= rd_data_next;
    end
  end

  // oscillator enable: held on by the option, off during reset
  always_ff @(posedge i_sys_clk or negedge i_rst_b) begin
    if (!i_rst_b) o_low_speed_osc_en <= 1'b0;
    else o_low_speed_osc_en <= !strap_taken_reg || nonstop_reg
                               || !i_low_speed_sw_stop;
  end

  // checks
  a_mode_reset: assert property (@(posedge i_sys_clk)
    $rose(i_rst_b) |-> watchdog_mode_reg == kwdt_pkg::MODE_RESET && width == 5'h12)
    else $error("mode register not at reset value");
  a_second_write: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    mode_again && !first_stopped_reg |=> o_internal_reset)
    else $error("second mode write did not reset");
  a_mode_once: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    mode_written_reg |=> $stable(watchdog_mode_reg))
    else $error("mode register changed after first write");
  a_stopped_forgive: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    first_stopped_reg && !wrap |=> !o_internal_reset)
    else $error("reset despite stopped watchdog");
  a_key_clear: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    key_good && !wrap |=> count_val == '0 && !o_internal_reset)
    else $error("restart key did not clear counter");
  a_key_bad: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    key_bad && !first_stopped_reg |=> o_internal_reset)
    else $error("bad key access did not reset");
  a_key_read: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    i_rd && sel_key |=> o_rd_data == 8'h9A)
    else $error("key register read wrong value");
  a_overflow: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    wrap |=> o_internal_reset && o_watchdog_reset_cause_flag && count_val == '0)
    else $error("overflow did not reset and flag");
  a_pause_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    (i_halt || i_stop) && !nonstop_reg && !clear |=> $stable(count_val))
    else $error("counter moved while paused");
  a_nonstop_src: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    nonstop_reg |-> !src_system && !wdt_stopped && o_low_speed_osc_en)
    else $error("non-stoppable option not honoured");
  // gating per source, stopped hold and sticky cause flag
  a_sys_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    src_system && (i_system_clk_stopped || i_osc_stabilizing) && !clear |=> $stable(count_val))
    else $error("system-clock count moved while gated");
  a_low_gate: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    !src_system && i_cpu_on_system_clk && i_low_speed_sw_stop && !nonstop_reg && !clear
    |=> $stable(count_val))
    else $error("low-speed count moved while oscillator stopped");
  a_stopped_hold: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    wdt_stopped && !clear |=> $stable(count_val))
    else $error("counter moved while watchdog stopped");
  a_flag_sticky: assert property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    o_watchdog_reset_cause_flag |=> o_watchdog_reset_cause_flag)
    else $error("cause flag cleared without reset");
  // covers for the main scenarios
  c_key_restart: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) key_good);
  c_overflow: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b) wrap);
  c_stop_first: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    first_stopped_reg && mode_again);
  c_nonstop_stop: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    nonstop_reg && i_stop && wrap);
  c_sys_gated: cover property (@(posedge i_sys_clk) disable iff (!i_rst_b)
    src_system && i_osc_stabilizing);
endmodule // kwdt_top
`default_nettype wire

// ### test/test_keyed_watchdog_timer.sv
// self-checking testbench for the keyed watchdog timer
`default_nettype none
module test_keyed_watchdog_timer;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_sys_clk = 1'b0;
  logic i_rst_b = 1'b0;
  logic [15:0] i_addr = 16'h0000;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_bit_op = 1'b0;
  logic [7:0] i_wr_data = 8'h00;
  logic i_option_nonstop = 1'b0;
  logic i_low_speed_osc_clk = 1'b0;
  logic i_halt = 1'b0;
  logic i_stop = 1'b0;
  logic i_system_clk_stopped = 1'b0;
  logic i_osc_stabilizing = 1'b0;
  logic i_cpu_on_system_clk = 1'b0;
  logic i_low_speed_sw_stop = 1'b0;
  logic [7:0] o_rd_data;
  logic o_internal_reset;
  logic o_watchdog_reset_cause_flag;
  logic o_low_speed_osc_en;
  int fails = 0;
  int n_compared = 0;
  localparam logic [15:0] M = kwdt_pkg::MODE_ADDR;
  localparam logic [15:0] K = kwdt_pkg::KEY_ADDR;

  kwdt_top DUT (.i_sys_clk, .i_rst_b, .i_addr, .i_wr, .i_rd, .i_bit_op, .i_wr_data, .o_rd_data,
    .i_option_nonstop, .i_low_speed_osc_clk, .i_halt, .i_stop, .i_system_clk_stopped,
    .i_osc_stabilizing, .i_cpu_on_system_clk, .i_low_speed_sw_stop, .o_internal_reset,
    .o_watchdog_reset_cause_flag, .o_low_speed_osc_en);

  // system clock 50 ns, low-speed oscillator 300 ns with its edges on system-clock falling edges
  always #25 i_sys_clk = ~i_sys_clk;
  always #150 i_low_speed_osc_clk = ~i_low_speed_osc_clk;

  task automatic report_and_stop();
    $display("fails=%0d n_compared=%0d", fails, n_compared);
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one strobe cycle, launched just after an edge and dropped after the taking edge
  task automatic acc(input logic w, input logic r, input logic b, input logic [15:0] a,
      input logic [7:0] d);
    @(posedge i_sys_clk);
    #5;
    i_wr = w;
    i_rd = r;
    i_bit_op = b;
    i_addr = a;
    i_wr_data = d;
    @(posedge i_sys_clk);
    #5;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_bit_op = 1'b0;
  endtask

  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b, input logic r);
    acc(1'b1, 1'b0, b, a, d);
    chk({7'h00, o_internal_reset}, {7'h00, r}); // pulse stands one cycle after taking edge
  endtask

  task automatic rd(input logic [15:0] a, input logic [7:0] exp);
    acc(1'b0, 1'b1, 1'b0, a, 8'h00);
    chk(o_rd_data, exp);
  endtask

  task automatic do_reset(input logic nonstop);
    #5;
    i_rst_b = 1'b0;
    i_option_nonstop = nonstop;
    repeat (8) @(posedge i_sys_clk);
    #5;
    chk({7'h00, o_watchdog_reset_cause_flag}, 8'h00);
    i_rst_b = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #5;
  endtask

  // counts edges until the overflow pulse and checks it lands in [lo, hi)
  task automatic wait_ovf(input int lo, input int hi);
    int n;
    n = 0;
    while (o_internal_reset !== 1'b1 && n < hi) begin
      @(posedge i_sys_clk);
      #5;
      n++;
    end
    chk({7'h00, (n >= lo && n < hi)}, 8'h01);
    chk({7'h00, o_watchdog_reset_cause_flag}, 8'h01);
  endtask

  // registers, keys, once-only mode write, system-source overflow and gating
  task automatic t_keys_and_system();
    do_reset(1'b0);
    rd(M, kwdt_pkg::MODE_RESET);
    rd(K, 8'h9A);
    rd(16'h0000, 8'h00);
    chk({7'h00, o_low_speed_osc_en}, 8'h01);
    wr(K, 8'hAC, 1'b0, 1'b0);
    wr(K, 8'h5A, 1'b0, 1'b1);
    wr(K, 8'hAC, 1'b1, 1'b1);
    wr(M, 8'h68, 1'b0, 1'b0);
    rd(M, 8'h68);
    wr(M, 8'h6F, 1'b0, 1'b1);
    rd(M, 8'h68);
    rd(K, 8'h9A);
    wr(K, 8'hAC, 1'b0, 1'b0);
    wait_ovf(8185, 8200);
    // pause 100 cycles each on halt, system clock stopped and stabilizing; a held count needs the full interval after
    i_halt = 1'b1;
    repeat (100) @(posedge i_sys_clk);
    #5;
    i_halt = 1'b0;
    i_system_clk_stopped = 1'b1;
    repeat (100) @(posedge i_sys_clk);
    #5;
    i_system_clk_stopped = 1'b0;
    i_osc_stabilizing = 1'b1;
    repeat (100) @(posedge i_sys_clk);
    #5;
    i_osc_stabilizing = 1'b0;
    wait_ovf(8185, 8200);
  endtask

  // stopped by the first write: later violations stay silent
  task automatic t_stopped();
    do_reset(1'b0);
    wr(M, 8'h70, 1'b0, 1'b0);
    rd(M, 8'h70);
    wr(M, 8'h67, 1'b0, 1'b0);
    wr(K, 8'h55, 1'b0, 1'b0);
    wr(K, 8'hAC, 1'b1, 1'b0);
    i_cpu_on_system_clk = 1'b1;
    i_low_speed_sw_stop = 1'b1;
    repeat (3) @(posedge i_sys_clk);
    #5;
    chk({7'h00, o_low_speed_osc_en}, 8'h00);
    i_cpu_on_system_clk = 1'b0;
    i_low_speed_sw_stop = 1'b0;
  endtask

  // non-stoppable option: select bits ignored, low-speed overflow even in stop
  task automatic t_nonstop();
    do_reset(1'b1);
    i_low_speed_sw_stop = 1'b1;
    wr(M, 8'h78, 1'b0, 1'b0);
    rd(M, 8'h60);
    chk({7'h00, o_low_speed_osc_en}, 8'h01);
    wr(K, 8'h00, 1'b0, 1'b1);
    wr(K, 8'hAC, 1'b0, 1'b0);
    i_stop = 1'b1;
    wait_ovf(12260, 12320);
    i_stop = 1'b0;
    i_low_speed_sw_stop = 1'b0;
  endtask

  initial begin
    t_keys_and_system();
    t_stopped();
    t_nonstop();
    report_and_stop();
  end

  // watchdog: tests need about 30000 cycles
  initial begin
    #3_000_000;
    fails++;
    report_and_stop();
  end
endmodule // test_keyed_watchdog_timer
`default_nettype wire
